// File: rtl/dio_defines.vh
/*
 * Constants for the drive input status and options register block:
 * host addresses, field positions, reset values and fixed read levels.
 * Assumes inclusion by bare name; of the block's rtl files only the dio_regs one includes it.
 */
`ifndef DIO_DEFINES_VH
`define DIO_DEFINES_VH

// ****************************************************************
// Host addresses
// ****************************************************************
`define DIO_ADDR_OUTPUT_CTRL  3'h2
`define DIO_ADDR_OPTIONS      3'h3
`define DIO_ADDR_DRIVE_INPUT  3'h7

// ****************************************************************
// Options register fields
// ****************************************************************
`define DIO_OPT_BOOT_BIT      0
`define DIO_OPT_SOFT_TERMINAL_COUNT_BIT      1
`define DIO_OPT_PCV_LO        2
`define DIO_OPT_PCV_HI        3
`define DIO_OPT_NWP_BIT       4
`define DIO_OPT_USED_MASK     8'h1F
`define DIO_OPT_RESET         8'h08

// ****************************************************************
// Output control register fields
// ****************************************************************
`define DIO_OCR_SEL_LO        0
`define DIO_OCR_SEL_HI        1
`define DIO_OCR_SRST_BIT      2
`define DIO_OCR_DMAEN_BIT     3
`define DIO_OCR_MOT_LO        4
`define DIO_OCR_MOT_HI        6
`define DIO_OCR_USED_MASK     8'h7F
`define DIO_OCR_RESET         8'h00

// ****************************************************************
// Drive input register fields and fixed levels
// ****************************************************************
`define DIO_DIR_HD_BIT        0
`define DIO_DIR_LOW_RATE_BIT  1
`define DIO_DIR_NWP_BIT       2
`define DIO_DIR_DMAEN_BIT     3
`define DIO_DIR_CHANGE_BIT    7
`define DIO_DIR_FILL_B        8'hFF
`define DIO_DIR_FILL_A        8'h00

// ****************************************************************
// Synchroniser idle levels: cs_n, rd_n, wr_n, addr, data
// ****************************************************************
`define DIO_BUS_SYNC_W        14
`define DIO_BUS_IDLE          14'h3800
`define DIO_PIN_SYNC_W        2
`define DIO_PIN_IDLE          2'h1

`endif

// File: rtl/dio_sync.v
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to core_clk; the output moves only
 * when stages two and three agree.
 */
`default_nettype none

module dio_sync #(
    parameter W        = 1,
    parameter [W-1:0] IDLE = {W{1'b0}}
) (
    input  wire         core_clk,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] stable
);

    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;
    integer     i;

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= IDLE;
            stage2 <= IDLE;
            stage3 <= IDLE;
            stable <= IDLE;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < W; i = i + 1)
            begin
                if (stage2[i] == stage3[i])
                    stable[i] <= stage3[i];
            end
        end
    end

endmodule

`default_nettype wire

// File: rtl/dio_drive_steer.v
/*
 * Drive select and motor enable steering with boot-drive swap.
 * Assumes select code and motor bits come from the output control
 * register on the same clock; all outputs are active low.
 */
`default_nettype none

module dio_drive_steer (
    input  wire       core_clk,
    input  wire       rst,
    input  wire [1:0] drive_sel,
    input  wire [2:0] motor_on,
    input  wire       boot_normal,
    output reg  [2:0] select_n,
    output reg  [2:0] motor_n
);

    reg [2:0] next_select_n;
    reg [2:0] next_motor_n;
    reg [2:0] logical_sel;

    always @*
    begin
        logical_sel = 3'h0;
        // Code 3 selects nothing
        case (drive_sel)                                          // R13
            2'h0:    logical_sel = 3'h1;
            2'h1:    logical_sel = 3'h2;
            2'h2:    logical_sel = 3'h4;
            default: logical_sel = 3'h0;
        endcase
        // A drive is selected only while its motor is enabled
        next_select_n = ~(logical_sel & motor_on);
        next_motor_n  = ~motor_on;
        if (!boot_normal)
        begin
            // Boot from drive 1: swap lines 0 and 1 in hardware
            next_select_n = {next_select_n[2], next_select_n[0],
                             next_select_n[1]};                   // R06
            next_motor_n  = {next_motor_n[2], next_motor_n[0],
                             next_motor_n[1]};                    // R06
        end
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            select_n <= 3'h7;
            motor_n  <= 3'h7;
        end
        else
        begin
            select_n <= next_select_n;
            motor_n  <= next_motor_n;
        end
    end

endmodule

`default_nettype wire

// File: rtl/dio_regs.v
/*
 * Drive input status and options register logic of a floppy
 * subsystem controller, with the output control register that
 * steers drive selects and motors.
 * Assumes an asynchronous host bus (chip select, read and write
 * strobes, three address bits, eight data bits) and a drive
 * disk-change pin and terminal count pin, all synchronised here.
 * Mode, rate and configuration inputs come from core_clk logic.
 */
// How it works
// R01: Address 7 with chip select low reads drive input; writes there are ignored.
// R02: Second mode: bit 0 is inverted high density, bit 7 disk change.
// R03: First mode: bits 1,2,3 low rate, precomp off, DMA enable; bit 7 inverted change.
// R04: Unused drive input bits read 1 in second mode, 0 in first.
// R05: Drive input read shows live signals; nothing is stored for it.
// R06: Options bit 0 clear swaps drive 0 and 1 selects and motors.
// R07: Options bit 1 lets software raise terminal count to the core.
// R08: Options bits 3:2 set precomp shift of one to four clocks.
// R09: Options bit 4 disables precomp, in the second mode only.
// R10: Shift unit is first clock, second clock at the 300 Kb/s rate.
// R11: First mode disables precomp from configuration bit 2 instead.
// R12: Reset clears options except bit 3, giving three clocks shift.
// R13: Output register bits 1:0 select drive 0, 1, 2; code 3 unsupported.
// R14: Software writes options to change settings and may read them back.
`default_nettype none

`include "dio_defines.vh"

module dio_regs (
    input  wire       core_clk,
    input  wire       rst,
    // Host bus pins
    input  wire       host_cs_n,
    input  wire       host_rd_n,
    input  wire       host_wr_n,
    input  wire [2:0] host_addr,
    input  wire [7:0] host_data_in,
    output reg  [7:0] host_data_out,
    output reg        host_data_oe,
    // Drive and controller pins
    input  wire       disk_change_n,
    input  wire       term_count_pin,
    // Core clock domain status
    input  wire       mode_first,
    input  wire       high_density_sel,
    input  wire       rate_low_sel,
    input  wire       rate_300k_sel,
    input  wire       cfg_precomp_off,
    // Drive steering, soft reset and DMA enable
    output wire       drive_zero_select_n,
    output wire       drive_one_select_n,
    output wire       drive_two_select_n,
    output wire       motor_zero_on_n,
    output wire       motor_one_on_n,
    output wire       motor_two_on_n,
    output reg        soft_reset_n,
    output reg        dma_irq_enable,
    // Core controller and precompensation unit
    output reg        core_term_count,
    output reg  [2:0] precomp_shift_clocks,
    output reg        precomp_enable,
    output reg        precomp_clk2_sel
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Shift in clocks is the code plus one
    function [2:0] shift_of;
        input [1:0] code;
        begin
            shift_of = {1'b0, code} + 3'h1;                       // R08
        end
    endfunction

    function is_addr;
        input [2:0] seen;
        input [2:0] want;
        begin
            is_addr = (seen == want);
        end
    endfunction

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    wire [`DIO_BUS_SYNC_W-1:0] bus_stable;
    wire [`DIO_PIN_SYNC_W-1:0] pin_stable;

    dio_sync #(
        .W    (`DIO_BUS_SYNC_W),
        .IDLE (`DIO_BUS_IDLE)
    ) u_bus_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({host_cs_n, host_rd_n, host_wr_n, host_addr,
                    host_data_in}),
        .stable   (bus_stable)
    );

    dio_sync #(
        .W    (`DIO_PIN_SYNC_W),
        .IDLE (`DIO_PIN_IDLE)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({term_count_pin, disk_change_n}),
        .stable   (pin_stable)
    );

    wire       cs_n_s      = bus_stable[13];
    wire       rd_n_s      = bus_stable[12];
    wire       wr_n_s      = bus_stable[11];
    wire [2:0] addr_s      = bus_stable[10:8];
    wire [7:0] data_s      = bus_stable[7:0];
    wire       disk_change = ~pin_stable[0];
    wire       tc_pin_s    = pin_stable[1];

    // ****************************************************************
    // Write strobe capture
    // ****************************************************************
    // Data hold after the strobe may be zero, so address and data are
    // held while the strobe is low and used at its rising edge.
    reg       wr_n_prev;
    reg [2:0] wr_addr_hold;
    reg [7:0] wr_data_hold;
    reg       wr_cs_hold;

    wire      write_done = ~wr_n_prev & wr_n_s;

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_n_prev    <= 1'b1;
            wr_addr_hold <= 3'h0;
            wr_data_hold <= 8'h00;
            wr_cs_hold   <= 1'b0;
        end
        else
        begin
            wr_n_prev <= wr_n_s;
            if (!wr_n_s)
            begin
                wr_addr_hold <= addr_s;
                wr_data_hold <= data_s;
                wr_cs_hold   <= ~cs_n_s;
            end
        end
    end

    wire wr_options = write_done & wr_cs_hold &
                      is_addr(wr_addr_hold, `DIO_ADDR_OPTIONS);
    wire wr_output  = write_done & wr_cs_hold &
                      is_addr(wr_addr_hold, `DIO_ADDR_OUTPUT_CTRL);

    // ****************************************************************
    // Options and output control registers
    // ****************************************************************
    reg [7:0] options;
    reg [7:0] output_control_reg;

    // Drive input address is read only: no write term exists for it
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            options            <= `DIO_OPT_RESET;                 // R12
            output_control_reg <= `DIO_OCR_RESET;
        end
        else
        begin
            if (wr_options)                                       // R01
                options <= wr_data_hold & `DIO_OPT_USED_MASK;
            if (wr_output)
                output_control_reg <= wr_data_hold & `DIO_OCR_USED_MASK;
        end
    end

    wire       boot_normal       = options[`DIO_OPT_BOOT_BIT];
    wire       soft_terminal_count = options[`DIO_OPT_SOFT_TERMINAL_COUNT_BIT];
    wire [1:0] precomp_shift_sel =
               options[`DIO_OPT_PCV_HI:`DIO_OPT_PCV_LO];
    wire       precomp_disable   = options[`DIO_OPT_NWP_BIT];
    wire       dma_enable_bit    = output_control_reg[`DIO_OCR_DMAEN_BIT];

    // ****************************************************************
    // Drive input register
    // ****************************************************************
    reg [7:0] drive_input;

    always @*
    begin
        if (mode_first)
        begin
            drive_input = `DIO_DIR_FILL_A;                        // R04
            drive_input[`DIO_DIR_LOW_RATE_BIT] = rate_low_sel;    // R03
            drive_input[`DIO_DIR_NWP_BIT]      = cfg_precomp_off; // R03
            drive_input[`DIO_DIR_DMAEN_BIT]    = dma_enable_bit;  // R03
            drive_input[`DIO_DIR_CHANGE_BIT]   = ~disk_change;    // R03
        end
        else
        begin
            drive_input = `DIO_DIR_FILL_B;                        // R04
            drive_input[`DIO_DIR_HD_BIT]     = ~high_density_sel; // R02
            drive_input[`DIO_DIR_CHANGE_BIT] = disk_change;       // R02
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Read data are refreshed every cycle of the strobe, so the bus
    // follows the live drive signals rather than a latched copy.
    reg       next_oe;
    reg [7:0] next_data;
    wire      reading = ~cs_n_s & ~rd_n_s;

    always @*
    begin
        next_oe   = 1'b0;
        next_data = 8'h00;
        if (reading)
        begin
            case (addr_s)
                `DIO_ADDR_DRIVE_INPUT:
                begin
                    next_oe   = 1'b1;                             // R01
                    next_data = drive_input;                      // R05
                end
                `DIO_ADDR_OPTIONS:
                begin
                    next_oe   = 1'b1;
                    next_data = options;                          // R14
                end
                default:
                begin
                    next_oe   = 1'b0;
                    next_data = 8'h00;
                end
            endcase
        end
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            host_data_oe  <= 1'b0;
            host_data_out <= 8'h00;
        end
        else
        begin
            host_data_oe  <= next_oe;
            host_data_out <= next_data;                           // R05
        end
    end

    // ****************************************************************
    // Drive steering
    // ****************************************************************
    wire [2:0] select_n_q;
    wire [2:0] motor_n_q;

    dio_drive_steer u_steer (
        .core_clk    (core_clk),
        .rst         (rst),
        .drive_sel   (output_control_reg[`DIO_OCR_SEL_HI:`DIO_OCR_SEL_LO]),
        .motor_on    (output_control_reg[`DIO_OCR_MOT_HI:`DIO_OCR_MOT_LO]),
        .boot_normal (boot_normal),
        .select_n    (select_n_q),
        .motor_n     (motor_n_q)
    );

    assign drive_zero_select_n = select_n_q[0];
    assign drive_one_select_n  = select_n_q[1];
    assign drive_two_select_n  = select_n_q[2];
    assign motor_zero_on_n     = motor_n_q[0];
    assign motor_one_on_n      = motor_n_q[1];
    assign motor_two_on_n      = motor_n_q[2];

    // ****************************************************************
    // Controller and precompensation outputs
    // ****************************************************************
    // Software count is a level: it stays asserted until cleared.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            soft_reset_n         <= 1'b0;
            dma_irq_enable       <= 1'b0;
            core_term_count      <= 1'b0;
            precomp_shift_clocks <= 3'h3;
            precomp_enable       <= 1'b0;
            precomp_clk2_sel     <= 1'b0;
        end
        else
        begin
            soft_reset_n    <= output_control_reg[`DIO_OCR_SRST_BIT];
            // Second mode treats the enable as always valid
            dma_irq_enable  <= mode_first ? dma_enable_bit : 1'b1;
            core_term_count <= soft_terminal_count | tc_pin_s;    // R07
            precomp_shift_clocks <= shift_of(precomp_shift_sel);  // R08
            if (mode_first)
                precomp_enable <= ~cfg_precomp_off;               // R11
            else
                precomp_enable <= ~precomp_disable;               // R09
            precomp_clk2_sel <= rate_300k_sel;                    // R10
        end
    end

endmodule

`default_nettype wire

// File: rtl/unused_placeholder_none.v
`default_nettype none
`default_nettype wire

// File: dv/dio_host.sv
/*
 * Host processor model on the parallel register bus.
 * Assumes core_clk comes from the bench; all pins move on falling edges.
 */
`default_nettype none

module dio_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe,
    output var  logic       host_cs_n,
    output var  logic       host_rd_n,
    output var  logic       host_wr_n,
    output var  logic [2:0] host_addr,
    output var  logic [7:0] host_data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Strobe width in cycles; raised to model a slow processor
    int strobe = 6;

    initial
    begin
        {host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_in} = 14'h3800;
    end

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {host_cs_n, host_wr_n, host_addr, host_data_in} = {2'b00, a, d};
        repeat (strobe) @(negedge core_clk);
        host_wr_n = 1'b1;
        repeat (strobe) @(negedge core_clk);
        host_cs_n = 1'b1;
        // Released bus must not keep showing the written byte
        host_data_in = ~d;
        repeat (strobe) @(negedge core_clk);
    endtask

    task rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
        @(negedge core_clk);
        {host_cs_n, host_rd_n, host_addr} = {2'b00, a};
        repeat (strobe + 1) @(negedge core_clk);
        d = host_data_out;
        oe = host_data_oe;
        {host_cs_n, host_rd_n} = 2'b11;
        repeat (strobe + 1) @(negedge core_clk);
    endtask
endmodule

`default_nettype wire

// File: dv/dio_regs_checker.sv
/*
 * Port-level assertions for the drive input and options registers.
 * Assumes binding to dio_regs; one clock, reset active high.
 */
`default_nettype none

module dio_regs_checker (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       host_cs_n,
    input  wire logic       host_rd_n,
    input  wire logic [2:0] host_addr,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe,
    input  wire logic       term_count_pin,
    input  wire logic       mode_first,
    input  wire logic       rate_300k_sel,
    input  wire logic       cfg_precomp_off,
    input  wire logic       drive_zero_select_n,
    input  wire logic       drive_one_select_n,
    input  wire logic       drive_two_select_n,
    input  wire logic       motor_two_on_n,
    input  wire logic       core_term_count,
    input  wire logic [2:0] precomp_shift_clocks,
    input  wire logic       precomp_enable,
    input  wire logic       precomp_clk2_sel
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence rd_end;
        $rose(host_rd_n);
    endsequence
    sequence tc_held;
        term_count_pin [*8];
    endsequence

    rd_cause_a:
    assert property ($rose(host_data_oe) |-> $past(!host_cs_n && !host_rd_n, 3)
        && ($past(host_addr, 3) inside {3'h3, 3'h7})) else $error("oe without read");
    oe_idle_a:
    assert property (!host_data_oe |-> host_data_out == 8'h00) else $error("data while idle");
    oe_drop_a:
    assert property (rd_end |-> ##[1:8] !host_data_oe) else $error("oe stuck");
    fill_b_a:
    assert property (host_data_oe && !mode_first
        && $past(!host_cs_n && !host_rd_n && host_addr == 3'h7, 4)
        |-> host_data_out[6:1] == 6'h3F) else $error("mode b fill");
    fill_a_a:
    assert property (host_data_oe && mode_first
        && $past(!host_cs_n && !host_rd_n && host_addr == 3'h7, 4)
        |-> host_data_out[6:4] == 3'h0 && !host_data_out[0]) else $error("mode a fill");
    sel_onehot_a:
    assert property ($onehot0({~drive_zero_select_n, ~drive_one_select_n,
        ~drive_two_select_n})) else $error("two drives selected");
    sel_motor_a:
    assert property (!drive_two_select_n |-> !motor_two_on_n) else $error("select no motor");
    shift_range_a:
    assert property (precomp_shift_clocks inside {[3'h1:3'h4]}) else $error("shift range");
    tc_pin_a:
    assert property (tc_held |=> core_term_count) else $error("tc not passed");
    clk2_track_a:
    assert property (!$past(rst) && $stable(rate_300k_sel)
        |-> precomp_clk2_sel == rate_300k_sel) else $error("clk2 select");
    pc_first_a:
    assert property (!$past(rst) && mode_first && $stable(mode_first)
        && $stable(cfg_precomp_off) |-> precomp_enable == !cfg_precomp_off)
        else $error("first mode precomp");
endmodule

bind dio_regs dio_regs_checker u_chk (
    .core_clk(core_clk), .rst(rst), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_addr(host_addr), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .term_count_pin(term_count_pin), .mode_first(mode_first),
    .rate_300k_sel(rate_300k_sel), .cfg_precomp_off(cfg_precomp_off),
    .drive_zero_select_n(drive_zero_select_n), .drive_one_select_n(drive_one_select_n),
    .drive_two_select_n(drive_two_select_n), .motor_two_on_n(motor_two_on_n),
    .core_term_count(core_term_count), .precomp_shift_clocks(precomp_shift_clocks),
    .precomp_enable(precomp_enable), .precomp_clk2_sel(precomp_clk2_sel)
);

`default_nettype wire

// File: dv/dio_regs_test.sv
/*
 * Self-checking bench for the drive input and options registers.
 * Assumes dio_regs and the dio_host model; no other stimulus source.
 */
`default_nettype none

module dio_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 0, rst = 1, disk_change_n = 1, term_count_pin = 0;
    logic mode_first = 0, high_density_sel = 0, rate_low_sel = 0;
    logic rate_300k_sel = 0, cfg_precomp_off = 0;
    logic host_cs_n, host_rd_n, host_wr_n, host_data_oe, rd_oe;
    logic [2:0] host_addr, precomp_shift_clocks;
    logic [7:0] host_data_in, host_data_out, rd_d;
    logic drive_zero_select_n, drive_one_select_n, drive_two_select_n;
    logic motor_zero_on_n, motor_one_on_n, motor_two_on_n, soft_reset_n;
    logic dma_irq_enable, core_term_count, precomp_enable, precomp_clk2_sel;
    int n_fail = 0, checks = 0, cyc = 0;
    wire [7:0] steer = {2'b00, drive_two_select_n, drive_one_select_n, drive_zero_select_n,
                        motor_two_on_n, motor_one_on_n, motor_zero_on_n};
    // {mode_first, high_density, rate_low, precomp_off, change_n}, expected byte
    logic [12:0] row [0:5] = '{13'h097E, 13'h00FF, 13'h077F, 13'h1582, 13'h1A04, 13'h1606};

    dio_regs u_dio_regs (.core_clk, .rst, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr,
        .host_data_in, .host_data_out, .host_data_oe, .disk_change_n, .term_count_pin,
        .mode_first, .high_density_sel, .rate_low_sel, .rate_300k_sel, .cfg_precomp_off,
        .drive_zero_select_n, .drive_one_select_n, .drive_two_select_n, .motor_zero_on_n,
        .motor_one_on_n, .motor_two_on_n, .soft_reset_n, .dma_irq_enable,
        .core_term_count, .precomp_shift_clocks, .precomp_enable, .precomp_clk2_sel);
    dio_host host (.core_clk, .host_data_out, .host_data_oe, .host_cs_n, .host_rd_n,
        .host_wr_n, .host_addr, .host_data_in);

    always #5 core_clk = ~core_clk;

    task give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Generous ceiling: the full sequence needs under 1000 cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task rdchk(input logic [2:0] a, input logic [7:0] e);
        host.rd(a, rd_d, rd_oe);
        chk("read_oe", 8'h01, {7'h00, rd_oe});
        chk("read_data", e, rd_d);
    endtask

    task pins(input logic [4:0] v);
        @(negedge core_clk);
        {mode_first, high_density_sel, rate_low_sel, cfg_precomp_off, disk_change_n} = v;
    endtask

    initial
    begin
        repeat (3) @(negedge core_clk);
        rst = 0;
        @(negedge core_clk);
        chk("shift_reset", 8'h03, {5'h00, precomp_shift_clocks});
        rdchk(3'h3, 8'h08);
        for (int i = 0; i < 6; i++)
        begin
            pins(row[i][12:8]);
            rdchk(3'h7, row[i][7:0]);
            chk("pc_en", {7'h00, row[i][12] ? ~row[i][9] : 1'b1}, {7'h00, precomp_enable});
        end
        pins(5'b00001);
        for (int v = 0; v < 4; v++)
        begin
            host.wr(3'h3, {4'h0, v[1:0], 2'b01});
            chk("shift", v[7:0] + 8'h01, {5'h00, precomp_shift_clocks});
            rdchk(3'h3, {4'h0, v[1:0], 2'b01});
        end
        host.wr(3'h3, 8'hE0);
        rdchk(3'h3, 8'h00);
        host.wr(3'h2, 8'h14);
        chk("steer_swap", 8'h2D, steer);
        chk("srst_set", 8'h01, {7'h00, soft_reset_n});
        chk("dma_b", 8'h01, {7'h00, dma_irq_enable});
        host.wr(3'h3, 8'h01);
        chk("steer_norm", 8'h36, steer);
        host.wr(3'h2, 8'h61);
        chk("steer_one", 8'h29, steer);
        host.wr(3'h2, 8'h42);
        chk("steer_two", 8'h1B, steer);
        host.wr(3'h2, 8'h73);
        chk("steer_none", 8'h38, steer);
        host.wr(3'h7, 8'h00);
        rdchk(3'h7, 8'h7F);
        rdchk(3'h3, 8'h01);
        host.rd(3'h2, rd_d, rd_oe);
        chk("oe_wonly", 8'h00, {7'h00, rd_oe});
        host.rd(3'h5, rd_d, rd_oe);
        chk("oe_unmapped", 8'h00, {7'h00, rd_oe});
        host.wr(3'h3, 8'h02);
        chk("tc_soft", 8'h01, {7'h00, core_term_count});
        host.wr(3'h3, 8'h11);
        chk("tc_clear", 8'h00, {7'h00, core_term_count});
        chk("nwp_b", 8'h00, {7'h00, precomp_enable});
        pins(5'b10001);
        host.wr(3'h2, 8'h08);
        chk("nwp_a", 8'h01, {7'h00, precomp_enable});
        chk("dma_a", 8'h01, {7'h00, dma_irq_enable});
        rdchk(3'h7, 8'h88);
        pins(5'b10011);
        @(negedge core_clk);
        chk("cfg_off", 8'h00, {7'h00, precomp_enable});
        term_count_pin = 1;
        repeat (12) @(negedge core_clk);
        chk("tc_pin", 8'h01, {7'h00, core_term_count});
        term_count_pin = 0;
        rate_300k_sel = 1;
        repeat (8) @(negedge core_clk);
        chk("tc_drop", 8'h00, {7'h00, core_term_count});
        chk("clk2", 8'h01, {7'h00, precomp_clk2_sel});
        host.strobe = 12;
        fork
            rdchk(3'h7, 8'h0C);
            begin
                repeat (3) @(negedge core_clk);
                disk_change_n = 0;
            end
        join
        host.strobe = 6;
        rst = 1;
        repeat (2) @(negedge core_clk);
        rst = 0;
        rdchk(3'h3, 8'h08);
        chk("dma_off", 8'h00, {7'h00, dma_irq_enable});
        chk("srst_off", 8'h00, {7'h00, soft_reset_n});
        give_verdict();
    end
endmodule

`default_nettype wire
